// *** vcc_pkg.sv ***
package vcc_pkg;
  localparam int VCC_CHANNELS = 16;
  localparam int VCC_VAC_W = 8;

  // byte addresses of the register words
  localparam logic [11:0] VCC_CFG_BASE = 12'h000;
  localparam logic [11:0] VCC_CMD_OFF = 12'h040;
  localparam logic [11:0] VCC_PART_OFF = 12'h044;
  localparam logic [11:0] VCC_SUPPLY_OFF = 12'h048;
  localparam logic [11:0] VCC_STAT_BASE = 12'h080;
  localparam logic [11:0] VCC_BANK_MASK = 12'hFC0;

  // channel configuration word fields
  localparam int VCC_CFG_AS_THR_LSB = 0;
  localparam int VCC_CFG_AS_HYS_LSB = 8;
  localparam int VCC_CFG_PP_THR_LSB = 16;
  localparam int VCC_CFG_VARIANT_LSB = 24;
  localparam int VCC_CFG_AS_EN_BIT = 26;
  localparam int VCC_CFG_VALVE_BIT = 27;
  localparam logic [27:0] VCC_CFG_RESET = 28'h0000000;

  // command word fields
  localparam int VCC_CMD_SUCTION_LSB = 0;
  localparam int VCC_CMD_BLOW_LSB = 16;
  localparam logic [31:0] VCC_CMD_RESET = 32'h00000000;

  // channel status word bits
  localparam int VCC_ST_NOZZLE_BIT = 0;
  localparam int VCC_ST_PAUSED_BIT = 1;
  localparam int VCC_ST_BLOW_BIT = 2;
  localparam int VCC_ST_PNEU_OFF_BIT = 3;
  localparam int VCC_ST_SPILOT_BIT = 4;
  localparam int VCC_ST_BPILOT_BIT = 5;
  localparam int VCC_ST_SLAMP_BIT = 6;
  localparam int VCC_ST_BLAMP_BIT = 7;
  localparam int VCC_ST_PART_BIT = 8;

  // pilot arrangement codes
  localparam logic [1:0] VCC_VAR_NC = 2'h0;
  localparam logic [1:0] VCC_VAR_NO = 2'h1;
  localparam logic [1:0] VCC_VAR_IMP = 2'h2;

  typedef enum logic [2:0] {
    VCC_NEUTRAL,
    VCC_SUCTION,
    VCC_PAUSED,
    VCC_BLOW,
    VCC_PNEU_OFF
  } vcc_state_type;
endpackage

// *** vcc_chan_if.sv ***
interface vcc_chan_if;
  import vcc_pkg::*;
  logic [VCC_VAC_W-1:0] air_saving_threshold;
  logic [VCC_VAC_W-1:0] air_saving_hysteresis;
  logic [VCC_VAC_W-1:0] part_present_threshold;
  logic [1:0] variant;
  logic air_saving_en;
  logic suction_cmd;
  logic blow_cmd;
  logic supply_ok;
  logic [VCC_VAC_W-1:0] vacuum;
  logic [8:0] status;
  modport ctrl (output air_saving_threshold, air_saving_hysteresis, part_present_threshold,
    variant, air_saving_en, suction_cmd, blow_cmd, supply_ok, vacuum, input status);
  modport chan (input air_saving_threshold, air_saving_hysteresis, part_present_threshold,
    variant, air_saving_en, suction_cmd, blow_cmd, supply_ok, vacuum, output status);
endinterface

// *** vcc_channel.sv ***
module vcc_channel
  import vcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  vcc_chan_if.chan ch
);
  vcc_state_type state_q, state_d;
  logic suction_prev_q;
  logic blow_prev_q;
  logic part_q;
  logic spilot_q, bpilot_q, slamp_q, blamp_q;
  logic [VCC_VAC_W-1:0] low_limit;
  logic nozzle_on;
  logic is_imp, is_no;

  // saturate so a hysteresis larger than the threshold cannot wrap
  assign low_limit = (ch.air_saving_threshold > ch.air_saving_hysteresis) ?
                     (ch.air_saving_threshold - ch.air_saving_hysteresis) : '0;
  assign is_imp = (ch.variant == VCC_VAR_IMP);
  assign is_no = (ch.variant == VCC_VAR_NO);
  assign nozzle_on = (state_q == VCC_SUCTION);

  always_comb begin
    state_d = state_q;
    if (!ch.supply_ok) begin
      case (state_q)
        VCC_BLOW: state_d = VCC_PNEU_OFF;
        VCC_PAUSED: state_d = VCC_SUCTION;
        default: state_d = state_q;
      endcase
    end else if (state_q == VCC_PNEU_OFF) begin
      // only a fresh command leaves the off state after supply returns
      if (ch.blow_cmd && !blow_prev_q) begin
        state_d = VCC_BLOW;
      end else if (ch.suction_cmd && !suction_prev_q && !ch.blow_cmd) begin
        state_d = VCC_SUCTION;
      end
    end else if (ch.blow_cmd) begin
      state_d = VCC_BLOW;
    end else if (ch.suction_cmd) begin
      case (state_q)
        VCC_SUCTION: begin
          if (ch.air_saving_en && ch.vacuum >= ch.air_saving_threshold) begin
            state_d = VCC_PAUSED;
          end
        end
        VCC_PAUSED: begin
          if (!ch.air_saving_en || ch.vacuum < low_limit) begin
            state_d = VCC_SUCTION;
          end
        end
        default: state_d = VCC_SUCTION;
      endcase
    end else begin
      state_d = VCC_NEUTRAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= VCC_NEUTRAL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suction_prev_q <= 1'b0;
      blow_prev_q <= 1'b0;
    end else begin
      suction_prev_q <= ch.suction_cmd;
      blow_prev_q <= ch.blow_cmd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_q <= 1'b0;
    end else begin
      part_q <= (ch.vacuum >= ch.part_present_threshold);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spilot_q <= 1'b0;
      bpilot_q <= 1'b0;
      slamp_q <= 1'b0;
      blamp_q <= 1'b0;
    end else begin
      // normally open pilot is energised to stop vacuum, so it inverts
      spilot_q <= is_no ? !nozzle_on : nozzle_on;
      bpilot_q <= (state_q == VCC_BLOW);
      slamp_q <= is_imp ? 1'b0 : (is_no ? !nozzle_on : nozzle_on);
      blamp_q <= (state_q == VCC_BLOW);
    end
  end

  always_comb begin
    ch.status = '0;
    ch.status[VCC_ST_NOZZLE_BIT] = nozzle_on;
    ch.status[VCC_ST_PAUSED_BIT] = (state_q == VCC_PAUSED);
    ch.status[VCC_ST_BLOW_BIT] = (state_q == VCC_BLOW);
    ch.status[VCC_ST_PNEU_OFF_BIT] = (state_q == VCC_PNEU_OFF);
    ch.status[VCC_ST_SPILOT_BIT] = spilot_q;
    ch.status[VCC_ST_BPILOT_BIT] = bpilot_q;
    ch.status[VCC_ST_SLAMP_BIT] = slamp_q;
    ch.status[VCC_ST_BLAMP_BIT] = blamp_q;
    ch.status[VCC_ST_PART_BIT] = part_q;
  end
endmodule // vcc_channel

// *** vcc_top.sv ***
// Local design decisions: the address map and register access over APB.
module vcc_top
  import vcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [VCC_CHANNELS*VCC_VAC_W-1:0] vacuum_level,
  input wire logic supply_ok,
  output logic [VCC_CHANNELS-1:0] suction_pilot,
  output logic [VCC_CHANNELS-1:0] blow_pilot,
  output logic [VCC_CHANNELS-1:0] suction_pilot_lamp,
  output logic [VCC_CHANNELS-1:0] blow_pilot_lamp,
  output logic [VCC_CHANNELS-1:0] part_present_lamp
);
  logic [27:0] cfg_q [VCC_CHANNELS];
  logic [31:0] cmd_q;
  logic [31:0] prdata_q;
  logic [VCC_CHANNELS*VCC_VAC_W-1:0] vac_meta_q, vac_sync_q;
  logic [VCC_CHANNELS*VCC_VAC_W-1:0] vac_hold_q, vac_q;
  logic supply_meta_q, supply_sync_q;
  logic [8:0] chan_status [VCC_CHANNELS];
  logic setup_phase;
  logic access_wr;
  logic [3:0] word_idx;
  logic word_aligned;
  logic hit_cfg, hit_stat, hit_cmd, hit_part, hit_supply;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [VCC_CHANNELS-1:0] part_vec;

  assign setup_phase = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign word_idx = paddr[5:2];
  assign word_aligned = (paddr[1:0] == 2'h0);
  assign hit_cfg = word_aligned && ((paddr & VCC_BANK_MASK) == VCC_CFG_BASE);
  assign hit_stat = word_aligned && ((paddr & VCC_BANK_MASK) == VCC_STAT_BASE);
  assign hit_cmd = (paddr == VCC_CMD_OFF);
  assign hit_part = (paddr == VCC_PART_OFF);
  assign hit_supply = (paddr == VCC_SUPPLY_OFF);
  // status words are read only; writing them is refused
  assign addr_ok = hit_cfg || hit_cmd || (!pwrite && (hit_stat || hit_part || hit_supply));

  // zero wait states: every access phase completes at its first edge
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_q;

  // sensor and supply arrive from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vac_meta_q <= '0;
      vac_sync_q <= '0;
      supply_meta_q <= 1'b0;
      supply_sync_q <= 1'b0;
    end else begin
      vac_meta_q <= vacuum_level;
      vac_sync_q <= vac_meta_q;
      supply_meta_q <= supply_ok;
      supply_sync_q <= supply_meta_q;
    end
  end

  // bits of one sensor word may cross a cycle apart; take all sixteen words once the whole sensor bus reads the same twice
  // limitation: a reading that never holds still for two cycles is not taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vac_hold_q <= '0;
      vac_q <= '0;
    end else begin
      vac_hold_q <= vac_sync_q;
      if (vac_sync_q == vac_hold_q) begin
        vac_q <= vac_sync_q;
      end
    end
  end

  // process data: the only path by which channels are commanded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= VCC_CMD_RESET;
    end else if (access_wr && hit_cmd) begin
      cmd_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < VCC_CHANNELS; i++) begin
        cfg_q[i] <= VCC_CFG_RESET;
      end
    end else if (access_wr && hit_cfg) begin
      cfg_q[word_idx] <= pwdata[27:0];
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_cfg) begin
      rd_mux = {4'h0, cfg_q[word_idx]};
    end else if (hit_stat) begin
      rd_mux = {23'h000000, chan_status[word_idx]};
    end else if (hit_cmd) begin
      rd_mux = cmd_q;
    end else if (hit_part) begin
      rd_mux = {16'h0000, part_vec};
    end else if (hit_supply) begin
      rd_mux = {31'h00000000, supply_sync_q};
    end
  end

  // read data captured in setup so it comes from a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // channel 0 sits next to the bus module
  for (genvar g = 0; g < VCC_CHANNELS; g++) begin : g_chan
    vcc_chan_if chif ();
    assign chif.air_saving_threshold = cfg_q[g][VCC_CFG_AS_THR_LSB +: VCC_VAC_W];
    assign chif.air_saving_hysteresis = cfg_q[g][VCC_CFG_AS_HYS_LSB +: VCC_VAC_W];
    assign chif.part_present_threshold = cfg_q[g][VCC_CFG_PP_THR_LSB +: VCC_VAC_W];
    assign chif.variant = cfg_q[g][VCC_CFG_VARIANT_LSB +: 2];
    assign chif.air_saving_en = cfg_q[g][VCC_CFG_AS_EN_BIT];
    assign chif.suction_cmd = cmd_q[VCC_CMD_SUCTION_LSB + g];
    assign chif.blow_cmd = cmd_q[VCC_CMD_BLOW_LSB + g];
    assign chif.supply_ok = supply_sync_q;
    assign chif.vacuum = vac_q[g*VCC_VAC_W +: VCC_VAC_W];
    assign chan_status[g] = chif.status;

    vcc_channel u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .ch(chif.chan)
    );

    assign suction_pilot[g] = chif.status[VCC_ST_SPILOT_BIT];
    assign blow_pilot[g] = chif.status[VCC_ST_BPILOT_BIT];
    assign suction_pilot_lamp[g] = chif.status[VCC_ST_SLAMP_BIT];
    assign blow_pilot_lamp[g] = chif.status[VCC_ST_BLAMP_BIT];
    assign part_vec[g] = chif.status[VCC_ST_PART_BIT];
    assign part_present_lamp[g] = chif.status[VCC_ST_PART_BIT];
  end
endmodule // vcc_top

// *** vcc_props.sv ***
module vcc_props
  import vcc_pkg::*;
(
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_ok,
  input wire logic [11:0] paddr,
  input wire logic [VCC_CHANNELS*VCC_VAC_W-1:0] vacuum_level,
  input wire logic [VCC_CHANNELS-1:0] suction_pilot, blow_pilot, suction_pilot_lamp,
  input wire logic [VCC_CHANNELS-1:0] blow_pilot_lamp, part_present_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  property p_blow_lamp; blow_pilot_lamp == blow_pilot; endproperty
  a_blow_lamp: assert property (p_blow_lamp) else $error("blow lamp off pilot");
  property p_suc_lamp; (suction_pilot_lamp & ~suction_pilot) == '0; endproperty
  a_suc_lamp: assert property (p_suc_lamp) else $error("suction lamp off pilot");
  property p_supply_blow; $fell(supply_ok) |-> ##[1:6] blow_pilot == '0; endproperty
  a_supply_blow: assert property (p_supply_blow) else $error("blow kept at loss");
  // blow pilot moves only after a bus write or while supply is away
  property p_blow_cause; $changed(blow_pilot) |-> $past(acc && pwrite, 2) ||
    $past(acc && pwrite, 3) || !($past(supply_ok, 3) && $past(supply_ok, 5)); endproperty
  a_blow_cause: assert property (p_blow_cause) else $error("blow pilot moved");
  property p_part; ($stable(vacuum_level) && !psel) [*6] |=> $stable(part_present_lamp);
  endproperty
  a_part: assert property (p_part) else $error("part lamp moved");
  property p_ro; acc && pwrite && (paddr == VCC_PART_OFF || paddr == VCC_SUPPLY_OFF ||
    (paddr & VCC_BANK_MASK) == VCC_STAT_BASE) |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("read-only write taken");
  property p_unal; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_unal: assert property (p_unal) else $error("unaligned access taken");
  property p_err; pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
endmodule // vcc_props
bind vcc_top vcc_props u_props (.*);

// *** vcc_ctrl_model.sv ***
module vcc_ctrl_model (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    // idle bus shows inverted values so no stale match
    paddr <= ~a;
    pwrite <= ~w;
    pwdata <= ~d;
  endtask
endmodule // vcc_ctrl_model

// *** test_vacuum_channel_control.sv ***
module test_vacuum_channel_control
  import vcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, supply_ok = 1, probe = 0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [127:0] vacuum_level = '0;
  logic [15:0] suction_pilot, blow_pilot, suction_pilot_lamp, blow_pilot_lamp, part_present_lamp;
  logic [79:0] qpin[$];
  logic [32:0] qrd[$];
  int fails = 0, checks_done = 0, seed = 32'h1349;
  logic [1:0] var_m[16] = '{default: 2'h0};
  logic [7:0] pp_m[16] = '{default: 8'h0};
  vcc_state_type st[16] = '{default: VCC_NEUTRAL};
  vcc_top dut (.*);
  vcc_ctrl_model u_ctrl (.*);
  initial forever #2.5 pclk = ~pclk;
  task automatic end_of_test();
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR prdata exp %h got %h", e, g);
    end
  endtask
  task automatic chk_pins(input logic [79:0] e, input logic [79:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR pins exp %h got %h", e, g);
    end
  endtask
  function automatic logic [79:0] pins();
    logic [79:0] r;
    logic noz;
    for (int g = 0; g < 16; g++) begin
      noz = st[g] == VCC_SUCTION;
      r[g] = (var_m[g] == VCC_VAR_NO) ? !noz : noz;
      r[16+g] = st[g] == VCC_BLOW;
      r[32+g] = (var_m[g] == VCC_VAR_IMP) ? 1'h0 : r[g];
      r[48+g] = r[16+g];
      r[64+g] = vacuum_level[8*g+:8] >= pp_m[g];
    end
    return r;
  endfunction
  function automatic logic [31:0] stw(input int g);
    logic [79:0] p;
    p = pins();
    return {23'h0, p[64+g], p[48+g], p[32+g], p[16+g], p[g], st[g] == VCC_PNEU_OFF,
      st[g] == VCC_BLOW, st[g] == VCC_PAUSED, st[g] == VCC_SUCTION};
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'h1)
      chk_rd(qrd.pop_front(), {pslverr, prdata});
    if (probe) chk_pins(qpin.pop_front(), {part_present_lamp, blow_pilot_lamp,
      suction_pilot_lamp, blow_pilot, suction_pilot});
  end
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    qrd.push_back(e);
    u_ctrl.xfer(a, 1'h0, 32'h0);
  endtask
  // fixed margin past the sync and state pipeline of every path
  task automatic settle();
    repeat (8) @(posedge pclk);
    qpin.push_back(pins());
    probe <= 1'h1;
    @(posedge pclk);
    probe <= 1'h0;
  endtask
  task automatic cfg(input int g, input logic [1:0] v, input logic [7:0] thr, hys, pp,
    input logic en, vlv);
    logic [31:0] w;
    w = {4'h0, vlv, en, v, pp, hys, thr};
    var_m[g] = v;
    pp_m[g] = pp;
    u_ctrl.xfer(VCC_CFG_BASE + 12'(4 * g), 1'h1, w);
    rd(VCC_CFG_BASE + 12'(4 * g), {1'h0, w});
  endtask
  task automatic cmd(input logic [15:0] s, b);
    for (int g = 0; g < 16; g++) st[g] = b[g] ? VCC_BLOW : (s[g] ? VCC_SUCTION : VCC_NEUTRAL);
    u_ctrl.xfer(VCC_CMD_OFF, 1'h1, {b, s});
  endtask
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
  initial begin
    int g, k;
    logic [7:0] vt[4] = '{8'h7F, 8'h80, 8'h70, 8'h6F};
    vcc_state_type et[4] = '{VCC_SUCTION, VCC_PAUSED, VCC_PAUSED, VCC_SUCTION};
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    vacuum_level <= {4{$random(seed)}};
    rd(VCC_CMD_OFF, 33'h0);
    rd(12'h0C0, {1'h1, 32'h0});
    rd(VCC_SUPPLY_OFF, 33'h1);
    u_ctrl.xfer(VCC_PART_OFF, 1'h1, 32'hFFFFFFFF);
    u_ctrl.xfer(12'h002, 1'h1, 32'hFFFFFFFF);
    for (int v = 0; v < 3; v++) begin
      g = $random(seed) & 15;
      cfg(g, v[1:0], 8'h0, 8'h0, 8'hFF, 1'h0, v[0]);
      for (int m = 0; m < 4; m++) begin
        cmd(m[0] ? 16'h1 << g : 16'h0, m[1] ? 16'h1 << g : 16'h0);
        settle();
      end
    end
    for (int vlv = 0; vlv < 2; vlv++) begin
      g = $random(seed) & 15;
      cfg(g, VCC_VAR_NC, 8'h80, 8'h10, 8'h80, 1'h1, vlv[0]);
      vacuum_level[8*g+:8] <= 8'h6F;
      cmd(16'h1 << g, 16'h0);
      for (int i = 0; i < 4; i++) begin
        vacuum_level[8*g+:8] <= vt[i];
        st[g] = et[i];
        settle();
      end
      rd(VCC_STAT_BASE + 12'(4 * g), {1'h0, stw(g)});
    end
    k = (g + 1) & 15;
    vacuum_level[8*g+:8] <= 8'h90;
    cmd(16'h1 << g, 16'h1 << k);
    st[g] = VCC_PAUSED;
    settle();
    supply_ok <= 1'h0;
    st[g] = VCC_SUCTION;
    st[k] = VCC_PNEU_OFF;
    settle();
    supply_ok <= 1'h1;
    st[g] = VCC_PAUSED;
    settle();
    rd(VCC_STAT_BASE + 12'(4 * k), {1'h0, stw(k)});
    end_of_test();
  end
endmodule // test_vacuum_channel_control
